// ---- core/dpsb_regs.svh ----
// Offsets, field positions, reset values of the preset select block.
// Assumes byte-wide registers reached as one 32-bit Avalon word each.
`ifndef DPSB_REGS_SVH
`define DPSB_REGS_SVH

// Register indices; byte address is four times the index
`define DPSB_IDX_SRC_MODE 12'h214
`define DPSB_IDX_PRESET_SEL 12'h215
`define DPSB_IDX_BINDING 12'h216
`define DPSB_IDX_RDIV_HI 12'h217
`define DPSB_IDX_RDIV_LO 12'h218
// Preset words: index base + preset, own choice
`define DPSB_IDX_FREQ_A_BASE 12'h220
`define DPSB_IDX_PHASE_A_BASE 12'h224
`define DPSB_IDX_FREQ_B_BASE 12'h228
`define DPSB_IDX_PHASE_B_BASE 12'h22C
// Status word showing live preset and power state, own choice
`define DPSB_IDX_STATUS 12'h230

// Reset values
`define DPSB_RST_SRC_MODE 8'h00
`define DPSB_RST_PRESET_SEL 8'h00
`define DPSB_RST_BINDING 8'h02
`define DPSB_RST_RDIV 16'h0000
`define DPSB_RST_FREQ 32'hC0000000
`define DPSB_RST_PHASE 16'h0000

// Field positions
`define DPSB_SEL_A_LSB 0
`define DPSB_SEL_B_LSB 2
`define DPSB_BIND_A_BIT 0
`define DPSB_BIND_B_BIT 1

// Misc sizes
`define DPSB_NUM_PRESETS 4
`define DPSB_WORD_ADDR_W 12

`endif

// ---- core/dpsb_pkg.sv ----
// Types shared by the preset select block.
// Assumes constants come from dpsb_regs.svh.
package dpsb_pkg;

    // Preset source modes; 3 is reserved
    typedef enum logic [1:0] {
        DPSB_SRC_REGISTER = 2'h0,
        DPSB_SRC_PINS_EACH = 2'h1,
        DPSB_SRC_PINS_SHARED = 2'h2,
        DPSB_SRC_RESERVED = 2'h3
    } dpsb_src_mode_t;

    typedef logic [1:0] dpsb_index_t;

endpackage

// ---- core/dpsb_preset_mem.sv ----
// Small register-array memory for four 32-bit presets words.
// Assumes one clock, synchronous reset, clock enable freezing state.
`timescale 1ns/1ps
`include "dpsb_regs.svh"

module dpsb_preset_mem #(
    parameter logic [31:0] RESET_WORD = 32'h00000000
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic wr_en_in,
    input wire logic [1:0] wr_idx_in,
    input wire logic [31:0] wr_data_in,
    input wire logic [1:0] rd_idx_in,
    input wire logic [1:0] act_idx_in,
    output logic [31:0] rd_data_out,
    output logic [31:0] act_data_out
);

    logic [31:0] mem [`DPSB_NUM_PRESETS];

    ////////////////////////////////////////////////////////////////////////
    // Storage, one entry per preset
    genvar g;
    generate
        for (g = 0; g < `DPSB_NUM_PRESETS; g++) begin : g_entry
            always_ff @(posedge clk_in) begin
                if (rst_in) begin
                    mem[g] <= RESET_WORD;
                end else if (ce_in && wr_en_in && wr_idx_in == 2'(g)) begin
                    mem[g] <= wr_data_in;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Registered read ports: bus and active preset
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rd_data_out <= RESET_WORD;
            act_data_out <= RESET_WORD;
        end else if (ce_in) begin
            rd_data_out <= mem[rd_idx_in];
            act_data_out <= mem[act_idx_in];
        end
    end

endmodule // dpsb_preset_mem

// ---- core/dpsb_top.sv ----
// Preset source selection, channel binding and NCO divisor registers.
// Assumes an Avalon-MM master on clk_in; preset pins are synchronised
// here; power-down requests come from the surrounding device.
`timescale 1ns/1ps
`include "dpsb_regs.svh"

module dpsb_top (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    // Avalon-MM slave, word addressed by byte address
    input wire logic [13:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [3:0] avs_byteenable_in,
    input wire logic [31:0] avs_writedata_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    output logic [1:0] avs_response_out,
    // Preset select pins
    input wire logic [1:0] preset_pins_a_in,
    input wire logic [1:0] preset_pins_b_in,
    // Converter input power-down requests
    input wire logic adc_a_powerdown_in,
    input wire logic adc_b_powerdown_in,
    // Outputs to the down-converter datapath
    output logic [31:0] ddc_a_frequency_word_out,
    output logic [15:0] ddc_a_phase_word_out,
    output logic [31:0] ddc_b_frequency_word_out,
    output logic [15:0] ddc_b_phase_word_out,
    output logic [1:0] ddc_a_active_index_out,
    output logic [1:0] ddc_b_active_index_out,
    output logic preset_valid_out,
    output logic [15:0] rational_reference_divisor_out,
    output logic channel_a_source_b_out,
    output logic channel_b_source_b_out,
    output logic channel_a_powerdown_out,
    output logic channel_b_powerdown_out,
    output logic link_a_powerdown_out,
    output logic link_b_powerdown_out
);

    logic [7:0] preset_source_mode_reg;
    logic [7:0] preset_index_select;
    logic [7:0] digital_channel_binding;
    logic [15:0] rational_reference_divisor;
    logic [1:0] pins_a_meta;
    logic [1:0] pins_a_sync;
    logic [1:0] pins_b_meta;
    logic [1:0] pins_b_sync;
    dpsb_pkg::dpsb_src_mode_t src_mode;
    dpsb_pkg::dpsb_index_t next_idx_a;
    dpsb_pkg::dpsb_index_t next_idx_b;
    logic next_valid;
    logic [11:0] word_idx;
    logic acc_pending;
    logic acc_done;
    logic wr_hit;
    logic [7:0] wr_byte;
    logic [15:0] wr_half;
    logic [31:0] wr_word;
    logic [1:0] rd_mem_phase;
    logic [1:0] sub_idx;
    logic wr_freq_a;
    logic wr_phase_a;
    logic wr_freq_b;
    logic wr_phase_b;
    logic [31:0] rd_freq_a;
    logic [31:0] rd_phase_a;
    logic [31:0] rd_freq_b;
    logic [31:0] rd_phase_b;
    logic [31:0] act_phase_a;
    logic [31:0] act_phase_b;
    logic [31:0] next_rdata;
    logic next_decerr;
    logic [1:0] mem_sel;

    ////////////////////////////////////////////////////////////////////////
    // Bus decode: one aligned word per register
    assign word_idx = avs_address_in[13:2];
    assign sub_idx = word_idx[1:0];
    assign acc_pending = avs_read_in || avs_write_in;
    // Three-cycle access: preset memory read register needs a stable
    // address for one edge before the read data register captures it
    assign acc_done = acc_pending && rd_mem_phase == 2'h2;
    assign avs_waitrequest_out = !acc_done;
    assign wr_hit = avs_write_in && acc_done && ce_in;

    // Disabled byte lanes forced to zero, with lane 0 carrying narrow registers
    always_comb begin
        wr_word = avs_writedata_in;
        for (int i = 0; i < 4; i++) begin
            if (!avs_byteenable_in[i]) begin
                wr_word[i*8 +: 8] = 8'h00;
            end
        end
        wr_byte = wr_word[7:0];
        wr_half = wr_word[15:0];
    end

    // Access phase count, cleared on completion
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rd_mem_phase <= 2'h0;
        end else if (ce_in) begin
            rd_mem_phase <= (acc_pending && !acc_done) ?
                rd_mem_phase + 2'h1 : 2'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Preset source mode register
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            preset_source_mode_reg <= `DPSB_RST_SRC_MODE;
        end else if (wr_hit && avs_byteenable_in[0] &&
                     word_idx == `DPSB_IDX_SRC_MODE) begin
            preset_source_mode_reg <= wr_byte;
        end
    end

    // Preset index select register
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            preset_index_select <= `DPSB_RST_PRESET_SEL;
        end else if (wr_hit && avs_byteenable_in[0] &&
                     word_idx == `DPSB_IDX_PRESET_SEL) begin
            preset_index_select <= wr_byte;
        end
    end

    // Channel binding register
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            digital_channel_binding <= `DPSB_RST_BINDING;
        end else if (wr_hit && avs_byteenable_in[0] &&
                     word_idx == `DPSB_IDX_BINDING) begin
            digital_channel_binding <= wr_byte;
        end
    end

    // Rational divisor, two byte registers
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rational_reference_divisor <= `DPSB_RST_RDIV;
        end else if (wr_hit && avs_byteenable_in[0]) begin
            if (word_idx == `DPSB_IDX_RDIV_HI) begin
                rational_reference_divisor[15:8] <= wr_byte;
            end else if (word_idx == `DPSB_IDX_RDIV_LO) begin
                rational_reference_divisor[7:0] <= wr_byte;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Preset word stores
    assign wr_freq_a = wr_hit && word_idx[11:2] == `DPSB_IDX_FREQ_A_BASE >> 2;
    assign wr_phase_a = wr_hit &&
        word_idx[11:2] == `DPSB_IDX_PHASE_A_BASE >> 2;
    assign wr_freq_b = wr_hit && word_idx[11:2] == `DPSB_IDX_FREQ_B_BASE >> 2;
    assign wr_phase_b = wr_hit &&
        word_idx[11:2] == `DPSB_IDX_PHASE_B_BASE >> 2;

    dpsb_preset_mem #(.RESET_WORD(`DPSB_RST_FREQ)) u_freq_a (
        .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
        .wr_en_in(wr_freq_a), .wr_idx_in(sub_idx), .wr_data_in(wr_word),
        .rd_idx_in(sub_idx), .act_idx_in(next_idx_a),
        .rd_data_out(rd_freq_a), .act_data_out(ddc_a_frequency_word_out)
    );
    dpsb_preset_mem #(.RESET_WORD(32'h00000000)) u_phase_a (
        .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
        .wr_en_in(wr_phase_a), .wr_idx_in(sub_idx),
        .wr_data_in({16'h0000, wr_half}),
        .rd_idx_in(sub_idx), .act_idx_in(next_idx_a),
        .rd_data_out(rd_phase_a), .act_data_out(act_phase_a)
    );
    dpsb_preset_mem #(.RESET_WORD(`DPSB_RST_FREQ)) u_freq_b (
        .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
        .wr_en_in(wr_freq_b), .wr_idx_in(sub_idx), .wr_data_in(wr_word),
        .rd_idx_in(sub_idx), .act_idx_in(next_idx_b),
        .rd_data_out(rd_freq_b), .act_data_out(ddc_b_frequency_word_out)
    );
    dpsb_preset_mem #(.RESET_WORD(32'h00000000)) u_phase_b (
        .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
        .wr_en_in(wr_phase_b), .wr_idx_in(sub_idx),
        .wr_data_in({16'h0000, wr_half}),
        .rd_idx_in(sub_idx), .act_idx_in(next_idx_b),
        .rd_data_out(rd_phase_b), .act_data_out(act_phase_b)
    );
    assign ddc_a_phase_word_out = act_phase_a[15:0];
    assign ddc_b_phase_word_out = act_phase_b[15:0];

    ////////////////////////////////////////////////////////////////////////
    // two-stage pin synchronisers
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pins_a_meta <= 2'h0;
            pins_a_sync <= 2'h0;
            pins_b_meta <= 2'h0;
            pins_b_sync <= 2'h0;
        end else if (ce_in) begin
            pins_a_meta <= preset_pins_a_in;
            pins_a_sync <= pins_a_meta;
            pins_b_meta <= preset_pins_b_in;
            pins_b_sync <= pins_b_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Active preset index selection
    assign src_mode = dpsb_pkg::dpsb_src_mode_t'(preset_source_mode_reg[1:0]);
    always_comb begin
        next_idx_a = ddc_a_active_index_out;
        next_idx_b = ddc_b_active_index_out;
        next_valid = 1'b1;
        unique case (src_mode)
            dpsb_pkg::DPSB_SRC_REGISTER: begin
                next_idx_a = preset_index_select[`DPSB_SEL_A_LSB +: 2];
                next_idx_b = preset_index_select[`DPSB_SEL_B_LSB +: 2];
            end
            dpsb_pkg::DPSB_SRC_PINS_EACH: begin
                next_idx_a = pins_a_sync;
                next_idx_b = pins_b_sync;
            end
            dpsb_pkg::DPSB_SRC_PINS_SHARED: begin
                next_idx_a = pins_a_sync;
                next_idx_b = pins_a_sync;
            end
            dpsb_pkg::DPSB_SRC_RESERVED: begin
                next_valid = 1'b0;
            end
        endcase
    end

    // Active index and validity registers
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ddc_a_active_index_out <= 2'h0;
            ddc_b_active_index_out <= 2'h0;
            preset_valid_out <= 1'b1;
        end else if (ce_in) begin
            ddc_a_active_index_out <= next_idx_a;
            ddc_b_active_index_out <= next_idx_b;
            preset_valid_out <= next_valid;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // one divisor for all presets
    assign rational_reference_divisor_out = rational_reference_divisor;

    // Binding outputs
    assign channel_a_source_b_out =
        digital_channel_binding[`DPSB_BIND_A_BIT];
    assign channel_b_source_b_out =
        digital_channel_binding[`DPSB_BIND_B_BIT];

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            channel_a_powerdown_out <= 1'b0;
            channel_b_powerdown_out <= 1'b0;
            link_a_powerdown_out <= 1'b0;
            link_b_powerdown_out <= 1'b0;
        end else if (ce_in) begin
            channel_a_powerdown_out <= channel_a_source_b_out ?
                adc_b_powerdown_in : adc_a_powerdown_in;
            channel_b_powerdown_out <= channel_b_source_b_out ?
                adc_b_powerdown_in : adc_a_powerdown_in;
            link_a_powerdown_out <= channel_a_source_b_out ?
                adc_b_powerdown_in : adc_a_powerdown_in;
            link_b_powerdown_out <= channel_b_source_b_out ?
                adc_b_powerdown_in : adc_a_powerdown_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read mux, registered one cycle before completion
    assign mem_sel = word_idx[3:2];
    always_comb begin
        next_rdata = 32'h00000000;
        next_decerr = 1'b0;
        if (word_idx == `DPSB_IDX_SRC_MODE) begin
            next_rdata = {24'h000000, preset_source_mode_reg};
        end else if (word_idx == `DPSB_IDX_PRESET_SEL) begin
            next_rdata = {24'h000000, preset_index_select};
        end else if (word_idx == `DPSB_IDX_BINDING) begin
            next_rdata = {24'h000000, digital_channel_binding};
        end else if (word_idx == `DPSB_IDX_RDIV_HI) begin
            next_rdata = {24'h000000, rational_reference_divisor[15:8]};
        end else if (word_idx == `DPSB_IDX_RDIV_LO) begin
            next_rdata = {24'h000000, rational_reference_divisor[7:0]};
        end else if (word_idx == `DPSB_IDX_STATUS) begin
            next_rdata = {20'h00000, channel_b_powerdown_out,
                channel_a_powerdown_out, 1'b0, preset_valid_out,
                ddc_b_active_index_out, ddc_a_active_index_out,
                4'h0};
        end else if (word_idx[11:4] == `DPSB_IDX_FREQ_A_BASE >> 4) begin
            // Preset arrays: A freq, A phase, B freq, B phase
            unique case (mem_sel)
                2'h0: next_rdata = rd_freq_a;
                2'h1: next_rdata = rd_phase_a;
                2'h2: next_rdata = rd_freq_b;
                2'h3: next_rdata = rd_phase_b;
            endcase
        end else begin
            next_decerr = 1'b1;
        end
    end

    // Read data and response registers
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            avs_readdata_out <= 32'h00000000;
            avs_response_out <= 2'h0;
        end else if (ce_in && acc_pending && rd_mem_phase == 2'h1) begin
            avs_readdata_out <= next_rdata;
            avs_response_out <= next_decerr ? 2'h3 : 2'h0;
        end
    end

endmodule // dpsb_top

// ---- verification/dpsb_sel_assertions.sv ----
// Checker for the preset select block, watching top ports only.
// Assumes writes land at the edge where waitrequest is sampled low.
`timescale 1ns/1ps
`include "dpsb_regs.svh"

module dpsb_sel_assertions (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [13:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic avs_waitrequest_out,
    input wire logic [1:0] preset_pins_a_in,
    input wire logic [1:0] preset_pins_b_in,
    input wire logic adc_a_powerdown_in,
    input wire logic adc_b_powerdown_in,
    input wire logic [1:0] ddc_a_active_index_out,
    input wire logic [1:0] ddc_b_active_index_out,
    input wire logic preset_valid_out,
    input wire logic [15:0] rational_reference_divisor_out,
    input wire logic channel_a_source_b_out,
    input wire logic channel_b_source_b_out,
    input wire logic channel_a_powerdown_out,
    input wire logic channel_b_powerdown_out,
    input wire logic link_a_powerdown_out,
    input wire logic link_b_powerdown_out
);
    logic [1:0] mode;
    logic [3:0] sel;
    logic [15:0] rdiv;
    logic [11:0] idx;
    logic wr_ok;
    logic want_a;
    logic want_b;

    // Decode of accepted writes and bound power-down sources
    assign idx = avs_address_in[13:2];
    assign wr_ok = avs_write_in && !avs_waitrequest_out;
    assign want_a = channel_a_source_b_out ? adc_b_powerdown_in
                                           : adc_a_powerdown_in;
    assign want_b = channel_b_source_b_out ? adc_b_powerdown_in
                                           : adc_a_powerdown_in;

    // Shadow copies of the mode, select and divisor registers
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            mode <= 2'h0;
            sel <= 4'h0;
            rdiv <= 16'h0000;
        end else if (wr_ok) begin
            if (idx == `DPSB_IDX_SRC_MODE) mode <= avs_writedata_in[1:0];
            if (idx == `DPSB_IDX_PRESET_SEL) sel <= avs_writedata_in[3:0];
            if (idx == `DPSB_IDX_RDIV_HI) rdiv[15:8] <= avs_writedata_in[7:0];
            if (idx == `DPSB_IDX_RDIV_LO) rdiv[7:0] <= avs_writedata_in[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    sequence s_req_start;
        $rose(avs_read_in || avs_write_in);
    endsequence
    sequence s_two_wait;
        avs_waitrequest_out ##1 avs_waitrequest_out ##1 !avs_waitrequest_out;
    endsequence

    a_wait_two: assert property (s_req_start |-> s_two_wait)
        else $error("bus access not answered after two waits");
    a_pd_chan_a: assert property (!$past(rst_in) |->
        channel_a_powerdown_out == $past(want_a) &&
        link_a_powerdown_out == channel_a_powerdown_out)
        else $error("channel A power-down wrong");
    a_pd_chan_b: assert property (!$past(rst_in) |->
        channel_b_powerdown_out == $past(want_b) &&
        link_b_powerdown_out == channel_b_powerdown_out)
        else $error("channel B power-down wrong");
    a_valid_mode: assert property (!$past(rst_in) |->
        preset_valid_out == ($past(mode) != 2'h3))
        else $error("preset valid flag wrong");
    a_index_reg: assert property (!$past(rst_in) &&
        $past(mode) == 2'h0 |->
        {ddc_b_active_index_out, ddc_a_active_index_out} == $past(sel))
        else $error("index not from select register");
    a_index_pins: assert property (!$past(rst_in) &&
        $past(mode) == 2'h1 |->
        ddc_a_active_index_out == $past(preset_pins_a_in, 3) &&
        ddc_b_active_index_out == $past(preset_pins_b_in, 3))
        else $error("index not from own pins");
    a_index_shared: assert property (!$past(rst_in) &&
        $past(mode) == 2'h2 |->
        ddc_a_active_index_out == $past(preset_pins_a_in, 3) &&
        ddc_b_active_index_out == $past(preset_pins_a_in, 3))
        else $error("index not from shared pins");
    a_index_hold: assert property (!$past(rst_in) &&
        $past(mode) == 2'h3 |->
        $stable(ddc_a_active_index_out) && $stable(ddc_b_active_index_out))
        else $error("index moved in reserved mode");
    a_div_track: assert property (
        rational_reference_divisor_out == rdiv)
        else $error("divisor differs from written bytes");
endmodule // dpsb_sel_assertions

// ---- verification/dpsb_pin_model.sv ----
// Far side model: preset-select pins and converter power-down lines.
// Assumes the bench commands values; they reach the pins an edge later.
`timescale 1ns/1ps

module dpsb_pin_model (
    input wire logic clk_in,
    input wire logic [5:0] cmd_in,
    output logic [5:0] lines_out
);
    initial lines_out = 6'h00;

    // pins move on the clock, unrelated to bus traffic
    always @(posedge clk_in) begin
        lines_out <= cmd_in;
    end
endmodule // dpsb_pin_model

// ---- verification/ddc_preset_select_and_bind_tb_top.sv ----
// Self-checking bench for the preset select and binding block.
// Assumes waitrequest answers every access and a 100 MHz clock.
`timescale 1ns/1ps
`include "dpsb_regs.svh"

module ddc_preset_select_and_bind_tb_top;
    typedef struct packed {
        logic [1:0] mode;
        logic [3:0] sel;
        logic [5:0] cmd;
        logic [1:0] ea;
        logic [1:0] eb;
        logic v;
    } dpsb_row_t;
    dpsb_row_t rows [5] = '{'{2'h0, 4'hE, 6'h01, 2'h2, 2'h3, 1'b1},
        '{2'h0, 4'h1, 6'h0B, 2'h1, 2'h0, 1'b1},
        '{2'h1, 4'hE, 6'h07, 2'h3, 2'h1, 1'b1},
        '{2'h2, 4'hE, 6'h09, 2'h1, 2'h1, 1'b1},
        '{2'h3, 4'h0, 6'h02, 2'h1, 2'h1, 1'b0}};
    logic [7:0] rst_exp [5] = '{8'h00, 8'h00, 8'h02, 8'h00, 8'h00};
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [13:0] avs_address_in = 14'h0000;
    logic avs_read_in = 1'b0;
    logic avs_write_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h00000000;
    logic [5:0] cmd = 6'h00;
    logic [5:0] lines;
    logic [31:0] rdata, avs_readdata_out;
    logic [31:0] ddc_a_frequency_word_out, ddc_b_frequency_word_out;
    logic [15:0] ddc_a_phase_word_out, ddc_b_phase_word_out;
    logic [15:0] rational_reference_divisor_out;
    logic [1:0] rresp, avs_response_out;
    logic [1:0] ddc_a_active_index_out, ddc_b_active_index_out;
    logic avs_waitrequest_out, preset_valid_out;
    logic channel_a_source_b_out, channel_b_source_b_out;
    logic channel_a_powerdown_out, channel_b_powerdown_out;
    logic link_a_powerdown_out, link_b_powerdown_out;
    int err_count = 0;
    int checks_done = 0;

    always #5 clk_in = ~clk_in;

    dpsb_pin_model u_pins (.clk_in, .cmd_in(cmd), .lines_out(lines));

    dpsb_top uut (.clk_in, .rst_in, .ce_in(1'b1), .avs_address_in,
        .avs_read_in, .avs_write_in, .avs_byteenable_in(4'hF),
        .avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out,
        .avs_response_out, .preset_pins_a_in(lines[1:0]),
        .preset_pins_b_in(lines[3:2]), .adc_a_powerdown_in(lines[4]),
        .adc_b_powerdown_in(lines[5]), .ddc_a_frequency_word_out,
        .ddc_a_phase_word_out, .ddc_b_frequency_word_out,
        .ddc_b_phase_word_out, .ddc_a_active_index_out,
        .ddc_b_active_index_out, .preset_valid_out,
        .rational_reference_divisor_out, .channel_a_source_b_out,
        .channel_b_source_b_out, .channel_a_powerdown_out,
        .channel_b_powerdown_out, .link_a_powerdown_out,
        .link_b_powerdown_out);

    ////////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks_done++;
        if (seen !== want) begin
            err_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, want);
        end
    endtask

    // One Avalon access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [11:0] idx,
                       input logic [31:0] wd);
        @(posedge clk_in);
        avs_address_in <= {idx, 2'h0};
        avs_write_in <= wr;
        avs_read_in <= !wr;
        avs_writedata_in <= wd;
        do begin
            @(posedge clk_in);
        end while (avs_waitrequest_out !== 1'b0);
        rdata = avs_readdata_out;
        rresp = avs_response_out;
        avs_write_in <= 1'b0;
        avs_read_in <= 1'b0;
    endtask

    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Watchdog against a hung bus
    initial begin
        repeat (5000) @(posedge clk_in);
        err_count++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        repeat (8) @(posedge clk_in);
        rst_in <= 1'b0;
        check(ddc_a_frequency_word_out, `DPSB_RST_FREQ);
        check(32'({channel_b_source_b_out, channel_a_source_b_out}),
            32'h2);
        for (int i = 0; i < 5; i++) begin
            bus(1'b0, `DPSB_IDX_SRC_MODE + 12'(i), 32'h0);
            check(rdata, 32'(rst_exp[i]));
        end
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, `DPSB_IDX_FREQ_A_BASE + 12'(i), {30'h28000000, 2'(i)});
            bus(1'b1, `DPSB_IDX_FREQ_B_BASE + 12'(i), {30'h2C000000, 2'(i)});
            bus(1'b1, `DPSB_IDX_PHASE_B_BASE + 12'(i), {30'h00002C00, 2'(i)});
            bus(1'b1, `DPSB_IDX_PHASE_A_BASE + 12'(i), {30'h00002800, 2'(i)});
        end
        bus(1'b0, `DPSB_IDX_FREQ_B_BASE + 12'h2, 32'h0);
        check(rdata, {30'h2C000000, 2'h2});
        foreach (rows[i]) begin
            bus(1'b1, `DPSB_IDX_PRESET_SEL, 32'(rows[i].sel));
            bus(1'b1, `DPSB_IDX_SRC_MODE, 32'(rows[i].mode));
            cmd <= rows[i].cmd;
            repeat (6) @(posedge clk_in);
            check(32'(ddc_a_active_index_out), 32'(rows[i].ea));
            check(32'(ddc_b_active_index_out), 32'(rows[i].eb));
            check(32'(preset_valid_out), 32'(rows[i].v));
            check(ddc_a_frequency_word_out, {30'h28000000, rows[i].ea});
            check(ddc_b_frequency_word_out, {30'h2C000000, rows[i].eb});
            check(32'(ddc_b_phase_word_out), {30'h2C00, rows[i].eb});
            check(32'(ddc_a_phase_word_out), {30'h2800, rows[i].ea});
        end
        // link and channel power-down follow the bound converter request
        for (int b = 0; b < 4; b++) begin
            bus(1'b1, `DPSB_IDX_BINDING, 32'(b));
            for (int p = 0; p < 4; p++) begin
                cmd <= 6'(p << 4);
                repeat (3) @(posedge clk_in);
                check(32'({link_b_powerdown_out, link_a_powerdown_out,
                    channel_b_powerdown_out, channel_a_powerdown_out}),
                    32'({2{b[1] ? p[1] : p[0], b[0] ? p[1] : p[0]}}));
            end
            check(32'({channel_b_source_b_out, channel_a_source_b_out}),
                32'(b));
        end
        bus(1'b1, `DPSB_IDX_BINDING, 32'h2);
        bus(1'b1, `DPSB_IDX_RDIV_HI, 32'h000000AB);
        bus(1'b1, `DPSB_IDX_RDIV_LO, 32'h000000CD);
        bus(1'b0, `DPSB_IDX_RDIV_HI, 32'h0);
        check(rdata, 32'h000000AB);
        check(32'(rational_reference_divisor_out), 32'h0000ABCD);
        bus(1'b0, 12'h219, 32'h0);
        check({rdata[29:0], rresp}, 32'h3);
        // Second reset in mid-run
        @(posedge clk_in);
        rst_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        rst_in <= 1'b0;
        check(32'(rational_reference_divisor_out), 32'h0);
        bus(1'b0, `DPSB_IDX_BINDING, 32'h0);
        check(rdata, 32'h2);
        report_and_stop();
    end
endmodule // ddc_preset_select_and_bind_tb_top

bind dpsb_top dpsb_sel_assertions u_chk (.clk_in, .rst_in, .avs_address_in,
    .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_waitrequest_out,
    .preset_pins_a_in, .preset_pins_b_in, .adc_a_powerdown_in,
    .adc_b_powerdown_in, .ddc_a_active_index_out, .ddc_b_active_index_out,
    .preset_valid_out, .rational_reference_divisor_out,
    .channel_a_source_b_out, .channel_b_source_b_out,
    .channel_a_powerdown_out, .channel_b_powerdown_out,
    .link_a_powerdown_out, .link_b_powerdown_out);
